// *** pkg/dppb_defines.svh ***
// Purpose: offsets, codes, limits and reset values of the drive profile register bank
// Assumes: 16-bit holding-register addressing, one register per address
// Notes: reset values are plain defaults, not factory values
`ifndef DPPB_DEFINES_SVH
`define DPPB_DEFINES_SVH

// register addresses
`define DPPB_ADDR_TARGET_FREQ 16'h0023
`define DPPB_ADDR_ACCEL_HI 16'h0024
`define DPPB_ADDR_ACCEL_LO 16'h0025
`define DPPB_ADDR_ACCEL_M2_HI 16'h0026
`define DPPB_ADDR_ACCEL_M2_LO 16'h0027
`define DPPB_ADDR_DECEL_HI 16'h0028
`define DPPB_ADDR_DECEL_LO 16'h0029
`define DPPB_ADDR_DECEL_M2_HI 16'h002a
`define DPPB_ADDR_DECEL_M2_LO 16'h002b
`define DPPB_ADDR_RUN_KEY_DIR 16'h002c
`define DPPB_ADDR_FREQ_SRC 16'h002d
`define DPPB_ADDR_RUN_CMD_SRC 16'h002e
`define DPPB_ADDR_BASE_FREQ 16'h002f
`define DPPB_ADDR_BASE_FREQ_M2 16'h0030
`define DPPB_ADDR_MAX_FREQ 16'h0031
`define DPPB_ADDR_MAX_FREQ_M2 16'h0032
`define DPPB_ADDR_ANALOG_SEL 16'h0033
`define DPPB_ADDR_RANGE_START_FREQ 16'h0034
`define DPPB_ADDR_RANGE_END_FREQ 16'h0035
`define DPPB_ADDR_RANGE_START_LEVEL 16'h0036
`define DPPB_ADDR_RANGE_END_LEVEL 16'h0037
`define DPPB_ADDR_STORE_ALL 16'h0900

// value limits
`define DPPB_FREQ_TENTHS_MAX 16'h0fa0
`define DPPB_START_FREQ_SCALE 16'h000a
`define DPPB_TIME_MIN 32'h0000_0001
`define DPPB_TIME_MAX 32'h0004_93e0
`define DPPB_TIME_COARSE 32'h0000_2710
`define DPPB_TIME_DIGIT 32'h0000_000a
`define DPPB_HZ_MIN 16'h001e
`define DPPB_HZ_MAX 16'h0190
`define DPPB_PCT_MAX 16'h0064
`define DPPB_RUN_DIR_MAX 16'h0001
`define DPPB_FREQ_SRC_MAX_LOW 16'h0003
`define DPPB_FREQ_SRC_CALC 16'h000a
`define DPPB_RUN_SRC_MIN 16'h0001
`define DPPB_RUN_SRC_MAX 16'h0003
`define DPPB_ANALOG_SEL_MAX 16'h0003

// reset values
`define DPPB_RST_TARGET_FREQ 16'h0000
`define DPPB_RST_TIME 32'h0000_03e8
`define DPPB_RST_RUN_DIR 16'h0000
`define DPPB_RST_FREQ_SRC 16'h0000
`define DPPB_RST_RUN_SRC 16'h0002
`define DPPB_RST_BASE_FREQ 16'h0032
`define DPPB_RST_MAX_FREQ 16'h0032
`define DPPB_RST_ANALOG_SEL 16'h0000
`define DPPB_RST_RANGE_FREQ 16'h0000
`define DPPB_RST_RANGE_START_LVL 16'h0000
`define DPPB_RST_RANGE_END_LVL 16'h0064

`endif

// *** pkg/dppb_pkg.sv ***
// Purpose: types shared by the drive profile register bank
// Assumes: constants live in dppb_defines.svh
// Notes: the setup struct is what the motor control reads
package dppb_pkg;

    // settings for one motor
    typedef struct packed {
        logic [31:0] accel_time;
        logic [31:0] decel_time;
        logic [15:0] base_freq;
        logic [15:0] max_freq;
    } dppb_motor_s;

    // whole bank as seen by the drive
    typedef struct packed {
        logic [15:0] target_output_freq;
        logic [15:0] run_key_direction;
        logic [15:0] freq_source_select;
        logic [15:0] run_cmd_source_select;
        logic [15:0] analog_input_select;
        logic [15:0] analog_range_start_freq;
        logic [15:0] analog_range_end_freq;
        logic [15:0] analog_range_start_level;
        logic [15:0] analog_range_end_level;
        dppb_motor_s m1;
        dppb_motor_s m2;
    } dppb_setup_s;

    // one holding-register access
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dppb_req_s;

endpackage : dppb_pkg

// *** core/dppb_bank.sv ***
// Purpose: holding-register bank with range checks for the drive motion profile and standard setup
// Assumes: a message decoder presents one register access per cycle; start frequency and store are ports
// Notes: answers in the cycle after the request; a rejected write leaves the register unchanged
// Operation
// - target frequency accepts zero or ten times start frequency to 4000 tenths
// - acceleration times are 32-bit, high word first, 1 to 300000, two motors
// - deceleration times use the same layout and range, two motors
// - times of 10000 or more drop the hundredths digit
// - run key direction accepts only 0 forward or 1 reverse
// - frequency source accepts codes 0 to 3 and 10
// - run command source accepts codes 1, 2, 3
// - motor one base frequency from 30 Hz up to its maximum frequency
// - motor two base frequency from 30 Hz up to its own maximum
// - maximum frequency from base frequency up to 400, never below 30
// - analog input selector accepts codes 0 to 3
// - analog range start and end frequency accept 0 to 4000 tenths
// - analog range start and end level accept 0 to 100 percent
// - values act at once; store command pulses the save of all data
`timescale 1ns/100ps
`include "dppb_defines.svh"

module dppb_bank
    import dppb_pkg::*;
(
    // clock and control
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    // register access from the network decoder
    input wire dppb_req_s req,
    input wire logic [15:0] start_freq,
    output logic ack,
    output logic nak,
    output logic [15:0] rdata,
    // setup to the drive and storage
    output dppb_setup_s setup,
    output logic store_pulse
);

    logic [15:0] tgt_reg, tgt_next;
    logic [31:0] acc_reg [2];
    logic [31:0] acc_next [2];
    logic [31:0] dec_reg [2];
    logic [31:0] dec_next [2];
    logic [15:0] base_reg [2];
    logic [15:0] base_next [2];
    logic [15:0] max_reg [2];
    logic [15:0] max_next [2];
    logic [15:0] hi_hold_reg, hi_hold_next;
    logic [15:0] dir_reg, dir_next;
    logic [15:0] fsrc_reg, fsrc_next;
    logic [15:0] rsrc_reg, rsrc_next;
    logic [15:0] asel_reg, asel_next;
    logic [15:0] rsf_reg, rsf_next;
    logic [15:0] ref_reg, ref_next;
    logic [15:0] rsl_reg, rsl_next;
    logic [15:0] rel_reg, rel_next;
    logic ack_reg, ack_next;
    logic nak_reg, nak_next;
    logic store_reg, store_next;
    logic [15:0] rdata_reg, rdata_next;
    logic [19:0] tgt_low;

    // drop hundredths on long times, keeping the value a multiple of ten
    function automatic logic [31:0] coarse(input logic [31:0] v);
        logic [31:0] r;
        r = v;
        if (v >= `DPPB_TIME_COARSE) begin
            r = v - (v % `DPPB_TIME_DIGIT);
        end
        return r;
    endfunction : coarse

    // time word legal range check
    function automatic logic time_ok(input logic [31:0] v);
        return (v >= `DPPB_TIME_MIN) && (v <= `DPPB_TIME_MAX);
    endfunction : time_ok

    // floor of the target; 20 bits so a large start frequency cannot wrap to a low floor
    assign tgt_low = 20'(start_freq) * 20'(`DPPB_START_FREQ_SCALE);

    // write decode, range check and read mux
    always_comb begin
        logic hit;
        logic ok;
        logic [15:0] d;
        hit = 1'b1;
        ok = 1'b1;
        d = req.wdata;
        tgt_next = tgt_reg;
        acc_next = acc_reg;
        dec_next = dec_reg;
        base_next = base_reg;
        max_next = max_reg;
        hi_hold_next = hi_hold_reg;
        dir_next = dir_reg;
        fsrc_next = fsrc_reg;
        rsrc_next = rsrc_reg;
        asel_next = asel_reg;
        rsf_next = rsf_reg;
        ref_next = ref_reg;
        rsl_next = rsl_reg;
        rel_next = rel_reg;
        store_next = 1'b0;
        rdata_next = 16'h0000;
        ack_next = 1'b0;
        nak_next = 1'b0;
        if (req.wr) begin
            case (req.addr)
                `DPPB_ADDR_TARGET_FREQ: begin
                    ok = (d == 16'h0000) ||
                         ({4'h0, d} >= tgt_low && d <= `DPPB_FREQ_TENTHS_MAX);
                    if (ok) tgt_next = d;
                end
                // high words are held until the low word completes the pair
                `DPPB_ADDR_ACCEL_HI, `DPPB_ADDR_ACCEL_M2_HI,
                `DPPB_ADDR_DECEL_HI, `DPPB_ADDR_DECEL_M2_HI: begin
                    ok = ({d, 16'h0000} <= `DPPB_TIME_MAX);
                    if (ok) hi_hold_next = d;
                end
                `DPPB_ADDR_ACCEL_LO: begin
                    ok = time_ok({hi_hold_reg, d});
                    if (ok) acc_next[0] = coarse({hi_hold_reg, d});
                end
                `DPPB_ADDR_ACCEL_M2_LO: begin
                    ok = time_ok({hi_hold_reg, d});
                    if (ok) acc_next[1] = coarse({hi_hold_reg, d});
                end
                `DPPB_ADDR_DECEL_LO: begin
                    ok = time_ok({hi_hold_reg, d});
                    if (ok) dec_next[0] = coarse({hi_hold_reg, d});
                end
                `DPPB_ADDR_DECEL_M2_LO: begin
                    ok = time_ok({hi_hold_reg, d});
                    if (ok) dec_next[1] = coarse({hi_hold_reg, d});
                end
                `DPPB_ADDR_RUN_KEY_DIR: begin
                    ok = (d <= `DPPB_RUN_DIR_MAX);
                    if (ok) dir_next = d;
                end
                `DPPB_ADDR_FREQ_SRC: begin
                    ok = (d <= `DPPB_FREQ_SRC_MAX_LOW) || (d == `DPPB_FREQ_SRC_CALC);
                    if (ok) fsrc_next = d;
                end
                `DPPB_ADDR_RUN_CMD_SRC: begin
                    ok = (d >= `DPPB_RUN_SRC_MIN) && (d <= `DPPB_RUN_SRC_MAX);
                    if (ok) rsrc_next = d;
                end
                `DPPB_ADDR_BASE_FREQ: begin
                    ok = (d >= `DPPB_HZ_MIN) && (d <= max_reg[0]);
                    if (ok) base_next[0] = d;
                end
                `DPPB_ADDR_BASE_FREQ_M2: begin
                    ok = (d >= `DPPB_HZ_MIN) && (d <= max_reg[1]);
                    if (ok) base_next[1] = d;
                end
                `DPPB_ADDR_MAX_FREQ: begin
                    ok = (d >= base_reg[0]) && (d >= `DPPB_HZ_MIN) && (d <= `DPPB_HZ_MAX);
                    if (ok) max_next[0] = d;
                end
                `DPPB_ADDR_MAX_FREQ_M2: begin
                    ok = (d >= base_reg[1]) && (d >= `DPPB_HZ_MIN) && (d <= `DPPB_HZ_MAX);
                    if (ok) max_next[1] = d;
                end
                `DPPB_ADDR_ANALOG_SEL: begin
                    ok = (d <= `DPPB_ANALOG_SEL_MAX);
                    if (ok) asel_next = d;
                end
                `DPPB_ADDR_RANGE_START_FREQ: begin
                    ok = (d <= `DPPB_FREQ_TENTHS_MAX);
                    if (ok) rsf_next = d;
                end
                `DPPB_ADDR_RANGE_END_FREQ: begin
                    ok = (d <= `DPPB_FREQ_TENTHS_MAX);
                    if (ok) ref_next = d;
                end
                `DPPB_ADDR_RANGE_START_LEVEL: begin
                    ok = (d <= `DPPB_PCT_MAX);
                    if (ok) rsl_next = d;
                end
                `DPPB_ADDR_RANGE_END_LEVEL: begin
                    ok = (d <= `DPPB_PCT_MAX);
                    if (ok) rel_next = d;
                end
                // any data value triggers the save
                `DPPB_ADDR_STORE_ALL: store_next = 1'b1;
                default: hit = 1'b0;
            endcase
            ack_next = hit && ok;
            nak_next = !(hit && ok);
        end else if (req.rd) begin
            case (req.addr)
                `DPPB_ADDR_TARGET_FREQ: rdata_next = tgt_reg;
                `DPPB_ADDR_ACCEL_HI: rdata_next = acc_reg[0][31:16];
                `DPPB_ADDR_ACCEL_LO: rdata_next = acc_reg[0][15:0];
                `DPPB_ADDR_ACCEL_M2_HI: rdata_next = acc_reg[1][31:16];
                `DPPB_ADDR_ACCEL_M2_LO: rdata_next = acc_reg[1][15:0];
                `DPPB_ADDR_DECEL_HI: rdata_next = dec_reg[0][31:16];
                `DPPB_ADDR_DECEL_LO: rdata_next = dec_reg[0][15:0];
                `DPPB_ADDR_DECEL_M2_HI: rdata_next = dec_reg[1][31:16];
                `DPPB_ADDR_DECEL_M2_LO: rdata_next = dec_reg[1][15:0];
                `DPPB_ADDR_RUN_KEY_DIR: rdata_next = dir_reg;
                `DPPB_ADDR_FREQ_SRC: rdata_next = fsrc_reg;
                `DPPB_ADDR_RUN_CMD_SRC: rdata_next = rsrc_reg;
                `DPPB_ADDR_BASE_FREQ: rdata_next = base_reg[0];
                `DPPB_ADDR_BASE_FREQ_M2: rdata_next = base_reg[1];
                `DPPB_ADDR_MAX_FREQ: rdata_next = max_reg[0];
                `DPPB_ADDR_MAX_FREQ_M2: rdata_next = max_reg[1];
                `DPPB_ADDR_ANALOG_SEL: rdata_next = asel_reg;
                `DPPB_ADDR_RANGE_START_FREQ: rdata_next = rsf_reg;
                `DPPB_ADDR_RANGE_END_FREQ: rdata_next = ref_reg;
                `DPPB_ADDR_RANGE_START_LEVEL: rdata_next = rsl_reg;
                `DPPB_ADDR_RANGE_END_LEVEL: rdata_next = rel_reg;
                default: hit = 1'b0;
            endcase
            ack_next = hit;
            nak_next = !hit;
        end
    end

    // state registers; clock enable freezes everything, but sys_rst still resets
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tgt_reg <= `DPPB_RST_TARGET_FREQ;
            for (int i = 0; i < 2; i++) begin
                acc_reg[i] <= `DPPB_RST_TIME;
                dec_reg[i] <= `DPPB_RST_TIME;
                base_reg[i] <= `DPPB_RST_BASE_FREQ;
                max_reg[i] <= `DPPB_RST_MAX_FREQ;
            end
            hi_hold_reg <= 16'h0000;
            dir_reg <= `DPPB_RST_RUN_DIR;
            fsrc_reg <= `DPPB_RST_FREQ_SRC;
            rsrc_reg <= `DPPB_RST_RUN_SRC;
            asel_reg <= `DPPB_RST_ANALOG_SEL;
            rsf_reg <= `DPPB_RST_RANGE_FREQ;
            ref_reg <= `DPPB_RST_RANGE_FREQ;
            rsl_reg <= `DPPB_RST_RANGE_START_LVL;
            rel_reg <= `DPPB_RST_RANGE_END_LVL;
            ack_reg <= 1'b0;
            nak_reg <= 1'b0;
            store_reg <= 1'b0;
            rdata_reg <= 16'h0000;
        end else if (clk_en) begin
            tgt_reg <= tgt_next;
            acc_reg <= acc_next;
            dec_reg <= dec_next;
            base_reg <= base_next;
            max_reg <= max_next;
            hi_hold_reg <= hi_hold_next;
            dir_reg <= dir_next;
            fsrc_reg <= fsrc_next;
            rsrc_reg <= rsrc_next;
            asel_reg <= asel_next;
            rsf_reg <= rsf_next;
            ref_reg <= ref_next;
            rsl_reg <= rsl_next;
            rel_reg <= rel_next;
            ack_reg <= ack_next;
            nak_reg <= nak_next;
            store_reg <= store_next;
            rdata_reg <= rdata_next;
        end
    end

    // outputs straight from flops, store pulse gated by the clock enable; setup is live, so writes act at once
    assign ack = ack_reg;
    assign nak = nak_reg;
    assign rdata = rdata_reg;
    assign store_pulse = store_reg && clk_en;
    assign setup.target_output_freq = tgt_reg;
    assign setup.run_key_direction = dir_reg;
    assign setup.freq_source_select = fsrc_reg;
    assign setup.run_cmd_source_select = rsrc_reg;
    assign setup.analog_input_select = asel_reg;
    assign setup.analog_range_start_freq = rsf_reg;
    assign setup.analog_range_end_freq = ref_reg;
    assign setup.analog_range_start_level = rsl_reg;
    assign setup.analog_range_end_level = rel_reg;
    assign setup.m1 = '{acc_reg[0], dec_reg[0], base_reg[0], max_reg[0]};
    assign setup.m2 = '{acc_reg[1], dec_reg[1], base_reg[1], max_reg[1]};

endmodule : dppb_bank

// *** bench/dppb_bank_monitor.sv ***
// Purpose: port-level checks of the drive profile register bank
// Assumes: clk_en stays high while a request waits for its answer
// Notes: bound to every instance of the bank
`timescale 1ns/100ps
module dppb_bank_monitor
    import dppb_pkg::*;
(
    // clock and control
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    // access side
    input wire dppb_req_s req,
    input wire logic [15:0] start_freq,
    input wire logic ack,
    input wire logic nak,
    input wire logic [15:0] rdata,
    // setup side
    input wire dppb_setup_s setup,
    input wire logic store_pulse
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // a request taken on an enabled edge
    wire logic taken = clk_en && (req.rd || req.wr);
    // a stored time must lie in range and be coarse from the threshold up
    function automatic logic t_ok(logic [31:0] t);
        return t >= 32'h1 && t <= 32'h0004_93e0 && (t < 32'h2710 || t % 32'ha == 32'h0);
    endfunction : t_ok

    // answers and refusals
    a_single_answer_next: assert property (taken |=> ack ^ nak)
        else $error("request without a single answer next cycle");
    a_idle_rdata_zero: assert property (!ack |-> rdata == 16'h0000)
        else $error("read data not zero outside an answer");
    a_reject_keeps_value: assert property (nak |-> setup == $past(setup))
        else $error("refused write changed the setup");
    // code sets and ranges held in the bank
    a_run_dir_code: assert property (setup.run_key_direction <= 16'h0001)
        else $error("run key direction out of code set");
    a_freq_src_code: assert property (setup.freq_source_select <= 16'h0003 || setup.freq_source_select == 16'h000a)
        else $error("frequency source out of code set");
    a_run_src_code: assert property (setup.run_cmd_source_select inside {[16'h0001:16'h0003]})
        else $error("run command source out of code set");
    a_analog_sel_level: assert property (setup.analog_input_select <= 16'h0003 && setup.analog_range_start_level <= 16'h0064 && setup.analog_range_end_level <= 16'h0064)
        else $error("analog selector or level out of range");
    a_range_freq_limit: assert property (setup.analog_range_start_freq <= 16'h0fa0 && setup.analog_range_end_freq <= 16'h0fa0)
        else $error("analog range frequency above limit");
    a_base_max_order: assert property (setup.m1.base_freq >= 16'h001e && setup.m1.base_freq <= setup.m1.max_freq && setup.m1.max_freq <= 16'h0190 && setup.m2.base_freq >= 16'h001e && setup.m2.base_freq <= setup.m2.max_freq && setup.m2.max_freq <= 16'h0190)
        else $error("base or maximum frequency out of order");
    a_time_coarse_range: assert property (t_ok(setup.m1.accel_time) && t_ok(setup.m1.decel_time) && t_ok(setup.m2.accel_time) && t_ok(setup.m2.decel_time))
        else $error("stored time out of range or not coarse");
    a_store_follows: assert property (taken && req.wr && req.addr == 16'h0900 |-> ##[1:2] store_pulse)
        else $error("store request without store pulse");
    a_freeze_holds_state: assert property (!clk_en |=> setup == $past(setup) && ack == $past(ack) && nak == $past(nak))
        else $error("state moved while the clock enable was low");
    // main scenarios reached
    c_write_ack: cover property (ack && !nak);
    c_refusal: cover property (nak);
    c_store: cover property (store_pulse);
endmodule : dppb_bank_monitor

bind dppb_bank dppb_bank_monitor dppb_bank_monitor_inst (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .req(req), .start_freq(start_freq), .ack(ack), .nak(nak), .rdata(rdata), .setup(setup),
    .store_pulse(store_pulse));

// *** bench/dppb_master_model.sv ***
// Purpose: network master that reads and writes the holding registers
// Assumes: one access at a time, answer within three cycles
// Notes: gap adds idle cycles before a request, to act slowly
`timescale 1ns/100ps
module dppb_master_model
    import dppb_pkg::*;
(
    // clock
    input wire logic clock,
    // answer from the bank
    input wire logic ack,
    input wire logic nak,
    input wire logic [15:0] rdata,
    // request to the bank
    output dppb_req_s req
);
    int gap = 0;
    initial req = '0;
    // released address and data show the inverse of the last value, never a stale copy
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic ok, output logic bad, output logic [15:0] q);
        int k;
        repeat (gap) @(posedge clock);
        @(posedge clock);
        #1;
        req = '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge clock);
        #1;
        req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        k = 0;
        while (!(ack || nak) && k < 3) begin
            @(posedge clock);
            #1;
            k++;
        end
        ok = ack;
        bad = nak;
        q = rdata;
    endtask : xfer
    // commit everything sent so far to storage
    task automatic store_all(output logic ok, output logic bad);
        logic [15:0] q;
        xfer(1'b1, 16'h0900, 16'h0001, ok, bad, q);
    endtask : store_all
endmodule : dppb_master_model

// *** bench/tb_drive_profile_parameter_bank.sv ***
// Purpose: self-checking bench of the drive profile register bank
// Assumes: start frequency 5, so the target floor is 50, except in the target checks at 100 and 13108
// Notes: a shadow of every register predicts each answer
`timescale 1ns/100ps
module tb_drive_profile_parameter_bank
    import dppb_pkg::*;
;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic [15:0] start_freq = 16'h0005;
    dppb_req_s req;
    logic ack, nak, store_pulse, ok, bad;
    logic [15:0] rdata, q, held;
    dppb_setup_s setup;
    int n_fail = 0;
    int cmp_count = 0;
    logic [31:0] lfsr = 32'h3bda560b;
    logic [15:0] shadow [16'h0023:16'h0037];
    logic [15:0] tab [8] = '{16'h0000, 16'h0031, 16'h0032, 16'h0fa0, 16'h0fa1, 16'h0190, 16'h001d, 16'h001e};
    logic [15:0] his [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0004, 16'h0004, 16'h0005};
    logic [15:0] los [6] = '{16'h0000, 16'h270f, 16'h2711, 16'h93e0, 16'h93e1, 16'h0001};

    always #2 clock = ~clock;

    dppb_bank dppb_bank_inst (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .req(req),
        .start_freq(start_freq), .ack(ack), .nak(nak), .rdata(rdata), .setup(setup), .store_pulse(store_pulse));
    dppb_master_model dppb_master_model_inst (.clock(clock), .ack(ack), .nak(nak), .rdata(rdata), .req(req));

    // next random word
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // reset contents: times 1000, run source 2, base and max 50, end level 100
    function automatic logic [15:0] rst_val(logic [15:0] a);
        case (a)
            16'h0025, 16'h0027, 16'h0029, 16'h002b: return 16'h03e8;
            16'h002e: return 16'h0002;
            16'h002f, 16'h0030, 16'h0031, 16'h0032: return 16'h0032;
            16'h0037: return 16'h0064;
            default: return 16'h0000;
        endcase
    endfunction : rst_val
    // acceptance of a single-word write, from the limits of each register
    function automatic logic legal(logic [15:0] a, logic [15:0] v);
        case (a)
            16'h0023: return v == 16'h0 || ({16'h0, v} >= {16'h0, start_freq} * 32'ha && v <= 16'h0fa0);
            16'h002c: return v <= 16'h0001;
            16'h002d: return v <= 16'h0003 || v == 16'h000a;
            16'h002e: return v >= 16'h0001 && v <= 16'h0003;
            16'h002f, 16'h0030: return v >= 16'h001e && v <= shadow[a + 16'h2];
            16'h0031, 16'h0032: return v >= 16'h001e && v <= 16'h0190 && v >= shadow[a - 16'h2];
            16'h0033: return v <= 16'h0003;
            16'h0034, 16'h0035: return v <= 16'h0fa0;
            default: return v <= 16'h0064;
        endcase
    endfunction : legal

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic go(input logic w, input logic [15:0] a, input logic [15:0] d);
        dppb_master_model_inst.xfer(w, a, d, ok, bad, q);
    endtask : go
    task automatic rd_chk(input logic [15:0] a);
        go(1'b0, a, 16'h0);
        chk({ok, bad, q}, {2'b10, shadow[a]});
    endtask : rd_chk
    // write, compare the answer with the prediction, read back
    task automatic put(input logic [15:0] a, input logic [15:0] d);
        logic acc;
        acc = legal(a, d);
        if (acc) shadow[a] = d;
        go(1'b1, a, d);
        chk({ok, bad}, {acc, !acc});
        rd_chk(a);
    endtask : put
    // two-word time: high word held, low word commits the pair
    task automatic tpair(input logic [15:0] h, input logic [15:0] hi, input logic [15:0] lo);
        logic [31:0] v;
        logic acc;
        go(1'b1, h, hi);
        chk({ok, bad}, {hi <= 16'h4, hi > 16'h4});
        if (hi <= 16'h4) held = hi;
        v = {held, lo};
        // range is judged on the value as sent, rounding applies only to what is kept
        acc = v >= 32'h1 && v <= 32'h0004_93e0;
        if (v >= 32'h2710) v = v - v % 32'ha;
        go(1'b1, h + 16'h1, lo);
        chk({ok, bad}, {acc, !acc});
        if (acc) {shadow[h], shadow[h + 16'h1]} = v;
        rd_chk(h);
        rd_chk(h + 16'h1);
    endtask : tpair
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    // watchdog: the whole sequence needs about 1000 cycles
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        close_out();
    end

    // main sequence
    initial begin
        held = 16'h0;
        for (int a = 16'h23; a <= 16'h37; a++) shadow[a] = rst_val(a[15:0]);
        repeat (6) @(posedge clock);
        #1 sys_rst = 1'b0;
        for (int a = 16'h23; a <= 16'h37; a++) rd_chk(a[15:0]);
        // every code 0..15 at each selector
        for (int v = 0; v < 16; v++) begin
            put(16'h002c, v[15:0]);
            put(16'h002d, v[15:0]);
            put(16'h002e, v[15:0]);
            put(16'h0033, v[15:0]);
        end
        // target bounds, then base and maximum edges for both motors
        foreach (tab[i]) put(16'h0023, tab[i]);
        // other start frequencies: floor of 1000, then a floor far above the limit
        start_freq = 16'h0064;
        put(16'h0023, 16'h03e7);
        put(16'h0023, 16'h03e8);
        start_freq = 16'h3334;
        put(16'h0023, 16'h0fa0);
        put(16'h0023, 16'h0000);
        start_freq = 16'h0005;
        for (int m = 0; m < 2; m++) begin
            put(16'h0031 + m[15:0], 16'h0191);
            foreach (tab[i]) put(16'h002f + m[15:0], tab[i]);
            foreach (tab[i]) put(16'h0031 + m[15:0], tab[i]);
        end
        for (int h = 16'h24; h <= 16'h2a; h += 2) begin
            foreach (his[i]) tpair(h[15:0], his[i], los[i]);
        end
        // random scaling values with a slow master now and then
        repeat (40) begin
            lfsr = lfsr_next(lfsr);
            dppb_master_model_inst.gap = int'(lfsr[31:30]);
            put(16'h0034 + {14'h0, lfsr[1:0]}, lfsr[1] ? {9'h0, lfsr[22:16]} : {4'h0, lfsr[27:16]});
        end
        clk_en = 1'b0;
        repeat (3) @(posedge clock);
        #1 clk_en = 1'b1;
        // unmapped places and the store
        go(1'b0, 16'h0022, 16'h0);
        chk({ok, bad, q}, {2'b01, 16'h0});
        go(1'b1, 16'h0038, 16'h0001);
        chk({ok, bad}, 2'b01);
        chk({31'h0, store_pulse}, 32'h0);
        go(1'b0, 16'h0900, 16'h0);
        chk({ok, bad, q}, {2'b01, 16'h0});
        dppb_master_model_inst.store_all(ok, bad);
        chk({ok, bad}, 2'b10);
        chk({31'h0, store_pulse}, 32'h1);
        chk(setup.m2.decel_time, {shadow[16'h2a], shadow[16'h2b]});
        chk({16'h0, setup.target_output_freq}, {16'h0, shadow[16'h23]});
        close_out();
    end
endmodule : tb_drive_profile_parameter_bank
